/* File: hw/jbs_tap.sv */
`timescale 1ns/1ps
// Contract
// - Traffic uses only the four test pins and standard controller sequencing.
// - Instruction register is sixteen bits and resets to 0x0000.
// - Code 0x0000 puts the boundary chain between data in and out.
// - Code 0x0002 puts the boundary chain in for observing and presetting.
// - Code 0x0004 selects the identification register.
// - Code 0xFFFF selects the one-bit bypass register.
// - Code 0x0082 selects the flash control register.
// - Code 0x0083 selects the flash data register.
// - Code 0x0084 selects the flash address register.
// - Seven instructions are decoded in total.
// - The boundary chain is 134 cells long.
// - Boundary drives pins only under the external test code, sample captures and presets without driving.
// - Cells 2 and 3 capture and update the reset line.
// - Cell 4 captures the oscillator input; its update does nothing.
// - Cell 5 captures and drives the weak-pullup enable.
// - First port occupies cells 6 to 21; even cells carry output enables.
// - Under the external test code all inputs to core logic read one.
// - Identification register is 32 bits wide.
module jbs_tap (
    input wire logic mclk,
    input wire logic rst,
    input wire logic tck,
    input wire jbs_pkg::jbs_jtag_in_t jtag_in,
    output jbs_pkg::jbs_jtag_out_t jtag_out,
    input wire jbs_pkg::jbs_pin_in_t pin_in,
    output jbs_pkg::jbs_pin_out_t pin_out,
    input wire jbs_pkg::jbs_core_drv_t core_drv,
    output jbs_pkg::jbs_core_in_t core_in
);
    import jbs_pkg::*;

    typedef struct packed {
        logic [IR_W-1:0] ir_sr;
        logic [IR_W-1:0] ir;
        jbs_dr_sel_t sel;
        logic ext;
        logic [BSR_W-1:0] bsr;
        logic [BSR_W-1:0] upd;
        logic upd_tg;
        logic byp;
        logic [ID_W-1:0] id;
        logic [FC_W-1:0] fc_sr;
        logic [FC_W-1:0] fc;
        logic [FA_W-1:0] fa_sr;
        logic [FA_W-1:0] fa;
        logic [FD_W-1:0] fd_sr;
        logic [FD_W-1:0] fd;
        logic [BSR_W-1:0] t1;
        logic [BSR_W-1:0] t2;
        logic [BSR_W-1:0] t3;
        logic [BSR_W-1:0] img;
    } jbs_tck_st_t;

    typedef struct packed {
        jbs_pin_in_t p1;
        jbs_pin_in_t p2;
        jbs_pin_in_t p3;
        jbs_pin_in_t pq;
        logic ext1;
        logic ext2;
        logic tg1;
        logic tg2;
        logic tg3;
        logic [BSR_W-1:0] upd;
        logic [BSR_W-1:0] img;
        jbs_pin_out_t pout;
        jbs_core_in_t cin;
    } jbs_mclk_st_t;

    jbs_tap_st_t st;
    jbs_tck_st_t t_r;
    jbs_tck_st_t t_nxt;
    jbs_mclk_st_t m_r;
    jbs_mclk_st_t m_nxt;
    jbs_jtag_out_t o_r;
    logic tdo_src;
    logic [BSR_W-1:0] img_v;
    logic [NPIN-1:0] upd_oe;
    logic [NPIN-1:0] upd_do;

    jbs_tap_fsm u_fsm (
        .tck(tck),
        .rst(rst),
        .tms(jtag_in.tms),
        .st(st)
    );

    function automatic jbs_dr_sel_t dec_sel(input logic [IR_W-1:0] code);
        case (code)
            OP_EXTEST: dec_sel = DR_BSR;
            OP_SAMPLE: dec_sel = DR_BSR;
            OP_IDCODE: dec_sel = DR_ID;
            OP_BYPASS: dec_sel = DR_BYP;
            OP_FL_CTRL: dec_sel = DR_FC;
            OP_FL_DATA: dec_sel = DR_FD;
            OP_FL_ADDR: dec_sel = DR_FA;
            default: dec_sel = DR_BYP;
        endcase
    endfunction

    // Boundary cell map: capture image and update fields per port pin.
    assign img_v[1:0] = 2'h0;
    assign img_v[CELL_RST_OE] = core_drv.rst_oe;
    assign img_v[CELL_RST_IO] = m_r.pq.rst_pin;
    assign img_v[CELL_OSC] = m_r.pq.osc;
    assign img_v[CELL_WPU] = core_drv.wpu_en;
    for (genvar n = 0; n < NPIN; n++) begin : g_cell
        assign img_v[CELL_PORT0 + 2 * n] = core_drv.port_oe[n];
        assign img_v[CELL_PORT0 + 2 * n + 1] = m_r.pq.port[n];
        assign upd_oe[n] = m_r.upd[CELL_PORT0 + 2 * n];
        assign upd_do[n] = m_r.upd[CELL_PORT0 + 2 * n + 1];
    end

    // Test-clock side: instruction and data registers.
    always_comb begin
        t_nxt = t_r;
        t_nxt.t1 = m_r.img;
        t_nxt.t2 = t_r.t1;
        t_nxt.t3 = t_r.t2;
        t_nxt.img = (~(t_r.t2 ^ t_r.t3) & t_r.t3) | ((t_r.t2 ^ t_r.t3) & t_r.img);
        case (st)
            TLR: begin
                t_nxt.ir = IR_RESET;
                t_nxt.sel = DR_BSR;
                t_nxt.ext = 1'b1;
            end
            CAP_IR: t_nxt.ir_sr = IR_CAPTURE;
            SH_IR: t_nxt.ir_sr = {jtag_in.tdi, t_r.ir_sr[IR_W-1:1]};
            UP_IR: begin
                t_nxt.ir = t_r.ir_sr;
                t_nxt.sel = dec_sel(t_r.ir_sr);
                t_nxt.ext = (t_r.ir_sr == OP_EXTEST);
            end
            CAP_DR: begin
                case (t_r.sel)
                    DR_BSR: t_nxt.bsr = t_r.img;
                    DR_ID: t_nxt.id = ID_VALUE;
                    DR_FC: t_nxt.fc_sr = t_r.fc;
                    DR_FD: t_nxt.fd_sr = t_r.fd;
                    DR_FA: t_nxt.fa_sr = t_r.fa;
                    default: t_nxt.byp = 1'b0;
                endcase
            end
            SH_DR: begin
                case (t_r.sel)
                    DR_BSR: t_nxt.bsr = {jtag_in.tdi, t_r.bsr[BSR_W-1:1]};
                    DR_ID: t_nxt.id = {jtag_in.tdi, t_r.id[ID_W-1:1]};
                    DR_FC: t_nxt.fc_sr = {jtag_in.tdi, t_r.fc_sr[FC_W-1:1]};
                    DR_FD: t_nxt.fd_sr = {jtag_in.tdi, t_r.fd_sr[FD_W-1:1]};
                    DR_FA: t_nxt.fa_sr = {jtag_in.tdi, t_r.fa_sr[FA_W-1:1]};
                    default: t_nxt.byp = jtag_in.tdi;
                endcase
            end
            UP_DR: begin
                case (t_r.sel)
                    DR_BSR: begin
                        t_nxt.upd = t_r.bsr;
                        t_nxt.upd_tg = ~t_r.upd_tg;
                    end
                    DR_FC: t_nxt.fc = t_r.fc_sr;
                    DR_FD: t_nxt.fd = t_r.fd_sr;
                    DR_FA: t_nxt.fa = t_r.fa_sr;
                    default: t_nxt.byp = t_r.byp;
                endcase
            end
            default: t_nxt.byp = t_r.byp;
        endcase
    end

    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            t_r <= '0;
            t_r.ir <= IR_RESET;
            t_r.sel <= DR_BSR;
            t_r.ext <= 1'b1;
            t_r.fc <= FC_RESET;
            t_r.fa <= FA_RESET;
            t_r.fd <= FD_RESET;
        end else begin
            t_r <= t_nxt;
        end
    end

    // Serial output mux; the pin changes on the falling test-clock edge.
    always_comb begin
        tdo_src = t_r.byp;
        if (st == SH_IR) begin
            tdo_src = t_r.ir_sr[0];
        end else begin
            case (t_r.sel)
                DR_BSR: tdo_src = t_r.bsr[0];
                DR_ID: tdo_src = t_r.id[0];
                DR_FC: tdo_src = t_r.fc_sr[0];
                DR_FD: tdo_src = t_r.fd_sr[0];
                DR_FA: tdo_src = t_r.fa_sr[0];
                default: tdo_src = t_r.byp;
            endcase
        end
    end

    always_ff @(negedge tck or posedge rst) begin
        if (rst) begin
            o_r <= '0;
        end else begin
            o_r.tdo <= tdo_src;
            o_r.tdo_oe <= (st == SH_IR) || (st == SH_DR);
        end
    end

    assign jtag_out = o_r;

    // System-clock side: pin sampling, update transfer and pin muxing.
    always_comb begin
        m_nxt = m_r;
        m_nxt.p1 = pin_in;
        m_nxt.p2 = m_r.p1;
        m_nxt.p3 = m_r.p2;
        m_nxt.pq = (~(m_r.p2 ^ m_r.p3) & m_r.p3) | ((m_r.p2 ^ m_r.p3) & m_r.pq);
        m_nxt.img = img_v;
        m_nxt.ext1 = t_r.ext;
        m_nxt.ext2 = m_r.ext1;
        m_nxt.tg1 = t_r.upd_tg;
        m_nxt.tg2 = m_r.tg1;
        m_nxt.tg3 = m_r.tg2;
        if (m_r.tg2 != m_r.tg3) begin
            m_nxt.upd = t_r.upd;
        end
        if (m_r.ext2) begin
            m_nxt.pout.rst_oe = m_r.upd[CELL_RST_OE];
            m_nxt.pout.rst_out = m_r.upd[CELL_RST_IO];
            m_nxt.pout.wpu_en = m_r.upd[CELL_WPU];
            m_nxt.pout.port_oe = upd_oe;
            m_nxt.pout.port_out = upd_do;
            m_nxt.cin = '1;
        end else begin
            m_nxt.pout.rst_oe = core_drv.rst_oe;
            m_nxt.pout.rst_out = 1'b0;
            m_nxt.pout.wpu_en = core_drv.wpu_en;
            m_nxt.pout.port_oe = core_drv.port_oe;
            m_nxt.pout.port_out = core_drv.port_out;
            m_nxt.cin.rst_pin = m_r.pq.rst_pin;
            m_nxt.cin.port = m_r.pq.port;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            m_r <= '0;
        end else begin
            m_r <= m_nxt;
        end
    end

    assign pin_out = m_r.pout;
    assign core_in = m_r.cin;

    a_ir_reset: assert property (@(posedge tck) disable iff (rst)
        st == TLR |=> t_r.ir == 16'h0000 && t_r.ext)
        else $error("Instruction register not cleared in reset state.");

    a_ir_capture: assert property (@(posedge tck) disable iff (rst)
        st == CAP_IR ##1 st == SH_IR |-> t_r.ir_sr[1:0] == 2'h1)
        else $error("Instruction capture pattern wrong.");

    a_sel_decode: assert property (@(posedge tck) disable iff (rst)
        st == UP_IR && t_r.ir_sr == 16'h1234 |=> t_r.sel == DR_BYP && !t_r.ext)
        else $error("Unassigned code did not select bypass.");

    a_sample_mode: assert property (@(posedge tck) disable iff (rst)
        st == UP_IR && t_r.ir_sr == 16'h0002 |=> t_r.sel == DR_BSR && !t_r.ext)
        else $error("Sample code decoded wrongly.");

    a_bypass_zero: assert property (@(posedge tck) disable iff (rst)
        st == CAP_DR && t_r.sel == DR_BYP |=> !t_r.byp)
        else $error("Bypass did not capture zero.");

    a_id_capture: assert property (@(posedge tck) disable iff (rst)
        st == CAP_DR && t_r.sel == DR_ID |=> t_r.id == ID_VALUE)
        else $error("Identification value not captured.");

    a_chain_shift: assert property (@(posedge tck) disable iff (rst)
        st == SH_DR && t_r.sel == DR_BSR
        |=> t_r.bsr[133] == $past(jtag_in.tdi) && t_r.bsr[132:0] == $past(t_r.bsr[133:1]))
        else $error("Boundary chain shift wrong.");

    a_osc_capture: assert property (@(posedge tck) disable iff (rst)
        st == CAP_DR && t_r.sel == DR_BSR |=> t_r.bsr[4] == $past(t_r.img[4]))
        else $error("Oscillator cell capture wrong.");

    a_core_forced: assert property (@(posedge mclk) disable iff (rst)
        m_r.ext2 |=> &m_r.cin)
        else $error("Core inputs not forced high in external test.");

    a_pin_hold: assert property (@(posedge mclk) disable iff (rst)
        !m_r.ext2 |=> m_r.pout.port_oe == $past(core_drv.port_oe))
        else $error("Boundary drove pins outside external test.");

    a_port_update: assert property (@(posedge mclk) disable iff (rst)
        m_r.ext2 |=> m_r.pout.port_oe[0] == $past(m_r.upd[6])
        && m_r.pout.port_out[63] == $past(m_r.upd[133]))
        else $error("Port cells did not drive pins.");

    a_rst_update: assert property (@(posedge mclk) disable iff (rst)
        m_r.ext2 |=> m_r.pout.rst_oe == $past(m_r.upd[2])
        && m_r.pout.wpu_en == $past(m_r.upd[5]))
        else $error("Reset or pullup cell did not drive.");

    a_ext_decode: assert property (@(posedge tck) disable iff (rst)
        st == UP_IR && t_r.ir_sr == OP_EXTEST |=> t_r.sel == DR_BSR && t_r.ext)
        else $error("External test code decoded wrongly.");

    a_id_select: assert property (@(posedge tck) disable iff (rst)
        st == UP_IR && t_r.ir_sr == OP_IDCODE |=> t_r.sel == DR_ID && !t_r.ext)
        else $error("Identification code decoded wrongly.");

    a_bypass_select: assert property (@(posedge tck) disable iff (rst)
        st == UP_IR && t_r.ir_sr == OP_BYPASS |=> t_r.sel == DR_BYP && !t_r.ext)
        else $error("Bypass code decoded wrongly.");

    a_fctl_select: assert property (@(posedge tck) disable iff (rst)
        st == UP_IR && t_r.ir_sr == OP_FL_CTRL |=> t_r.sel == DR_FC)
        else $error("Flash control code decoded wrongly.");

    a_fdat_select: assert property (@(posedge tck) disable iff (rst)
        st == UP_IR && t_r.ir_sr == OP_FL_DATA |=> t_r.sel == DR_FD)
        else $error("Flash data code decoded wrongly.");

    a_fadr_select: assert property (@(posedge tck) disable iff (rst)
        st == UP_IR && t_r.ir_sr == OP_FL_ADDR |=> t_r.sel == DR_FA)
        else $error("Flash address code decoded wrongly.");

    a_update_copy: assert property (@(posedge tck) disable iff (rst)
        st == UP_DR && t_r.sel == DR_BSR |=> t_r.upd == $past(t_r.bsr))
        else $error("Boundary update did not copy the chain.");

    a_ir_tdo: assert property (@(posedge tck) disable iff (rst)
        st == SH_IR |-> jtag_out.tdo == t_r.ir_sr[0] && jtag_out.tdo_oe)
        else $error("Instruction shift did not present its low bit.");

    a_id_tdo: assert property (@(posedge tck) disable iff (rst)
        st == SH_DR && t_r.sel == DR_ID |-> jtag_out.tdo == t_r.id[0] && jtag_out.tdo_oe)
        else $error("Identification shift did not present its low bit.");
endmodule

/* File: hw/jbs_pkg.sv */
package jbs_pkg;
    localparam int IR_W = 16;
    localparam int BSR_W = 134;
    localparam int ID_W = 32;
    localparam int FC_W = 8;
    localparam int FA_W = 16;
    localparam int FD_W = 20;
    localparam int NPIN = 64;
    localparam logic [15:0] IR_RESET = 16'h0000;
    localparam logic [15:0] IR_CAPTURE = 16'h0001;
    localparam logic [15:0] OP_EXTEST = 16'h0000;
    localparam logic [15:0] OP_SAMPLE = 16'h0002;
    localparam logic [15:0] OP_IDCODE = 16'h0004;
    localparam logic [15:0] OP_BYPASS = 16'hFFFF;
    localparam logic [15:0] OP_FL_CTRL = 16'h0082;
    localparam logic [15:0] OP_FL_DATA = 16'h0083;
    localparam logic [15:0] OP_FL_ADDR = 16'h0084;
    // Arbitrary identification value; bit 0 is set as the standard requires.
    localparam logic [31:0] ID_VALUE = 32'h1000_0001;
    localparam int CELL_RST_OE = 2;
    localparam int CELL_RST_IO = 3;
    localparam int CELL_OSC = 4;
    localparam int CELL_WPU = 5;
    localparam int CELL_PORT0 = 6;
    localparam int CELLS_PER_PORT = 16;
    localparam logic [FC_W-1:0] FC_RESET = 8'h00;
    localparam logic [FA_W-1:0] FA_RESET = 16'h0000;
    localparam logic [FD_W-1:0] FD_RESET = 20'h00000;

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UP_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UP_IR
    } jbs_tap_st_t;

    typedef enum logic [2:0] {
        DR_BSR, DR_BYP, DR_ID, DR_FC, DR_FD, DR_FA
    } jbs_dr_sel_t;

    typedef struct packed {
        logic tms;
        logic tdi;
    } jbs_jtag_in_t;

    typedef struct packed {
        logic tdo;
        logic tdo_oe;
    } jbs_jtag_out_t;

    typedef struct packed {
        logic rst_pin;
        logic osc;
        logic [NPIN-1:0] port;
    } jbs_pin_in_t;

    typedef struct packed {
        logic rst_oe;
        logic wpu_en;
        logic [NPIN-1:0] port_oe;
        logic [NPIN-1:0] port_out;
    } jbs_core_drv_t;

    typedef struct packed {
        logic rst_oe;
        logic rst_out;
        logic wpu_en;
        logic [NPIN-1:0] port_oe;
        logic [NPIN-1:0] port_out;
    } jbs_pin_out_t;

    typedef struct packed {
        logic rst_pin;
        logic [NPIN-1:0] port;
    } jbs_core_in_t;
endpackage

/* File: hw/jbs_tap_fsm.sv */
`timescale 1ns/1ps
module jbs_tap_fsm (
    input wire logic tck,
    input wire logic rst,
    input wire logic tms,
    output jbs_pkg::jbs_tap_st_t st
);
    import jbs_pkg::*;

    jbs_tap_st_t st_r;
    jbs_tap_st_t st_nxt;

    // Standard sixteen-state controller, advanced by the mode pin.
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            TLR: st_nxt = tms ? TLR : RTI;
            RTI: st_nxt = tms ? SEL_DR : RTI;
            SEL_DR: st_nxt = tms ? SEL_IR : CAP_DR;
            CAP_DR: st_nxt = tms ? EX1_DR : SH_DR;
            SH_DR: st_nxt = tms ? EX1_DR : SH_DR;
            EX1_DR: st_nxt = tms ? UP_DR : PA_DR;
            PA_DR: st_nxt = tms ? EX2_DR : PA_DR;
            EX2_DR: st_nxt = tms ? UP_DR : SH_DR;
            UP_DR: st_nxt = tms ? SEL_DR : RTI;
            SEL_IR: st_nxt = tms ? TLR : CAP_IR;
            CAP_IR: st_nxt = tms ? EX1_IR : SH_IR;
            SH_IR: st_nxt = tms ? EX1_IR : SH_IR;
            EX1_IR: st_nxt = tms ? UP_IR : PA_IR;
            PA_IR: st_nxt = tms ? EX2_IR : PA_IR;
            EX2_IR: st_nxt = tms ? UP_IR : SH_IR;
            UP_IR: st_nxt = tms ? SEL_DR : RTI;
            default: st_nxt = TLR;
        endcase
    end

    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            st_r <= TLR;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign st = st_r;
endmodule

/* File: bench/jbs_tester.sv */
`timescale 1ns/1ps
// Scan controller model: the test clock only runs while a sequence is in progress.
module jbs_tester (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // One test clock period; data out is only trusted while its enable is high.
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #40;
        o = tdo_oe ? tdo : 1'bx;
        tck = 1'b1;
        #40;
        tck = 1'b0;
    endtask

    task automatic tlr();
        logic o;
        repeat (5) step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask

    // Full scan from idle back to idle, least significant bit first.
    task automatic scan(input logic irs, input int n, input logic [159:0] din,
                        output logic [159:0] dout);
        logic o;
        dout = '0;
        step(1'b1, ~tdi, o);
        if (irs) begin
            step(1'b1, ~tdi, o);
        end
        step(1'b0, ~tdi, o);
        step(1'b0, ~tdi, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, ~tdi, o);
        step(1'b0, ~tdi, o);
    endtask
endmodule

/* File: bench/tb_jbs_tap.sv */
`timescale 1ns/1ps
module tb_jbs_tap;
    import jbs_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic tck;
    logic tms;
    logic tdi;
    jbs_jtag_in_t jtag_in;
    jbs_jtag_out_t jtag_out;
    jbs_pin_in_t pin_in;
    jbs_pin_out_t pin_out;
    jbs_core_drv_t core_drv;
    jbs_core_in_t core_in;
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    logic [159:0] so;
    logic [159:0] p1;

    assign jtag_in = {tms, tdi};
    always #5 mclk = ~mclk;

    jbs_tap jbs_tap_inst (.mclk(mclk), .rst(rst), .tck(tck), .jtag_in(jtag_in),
        .jtag_out(jtag_out), .pin_in(pin_in), .pin_out(pin_out),
        .core_drv(core_drv), .core_in(core_in));

    jbs_tester jbs_tester_inst (.tck(tck), .tms(tms), .tdi(tdi),
        .tdo(jtag_out.tdo), .tdo_oe(jtag_out.tdo_oe));

    task automatic chk(input string what, input logic [159:0] seen, input logic [159:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            failures++;
            conclude();
        end
    end

    task automatic ir(input logic [15:0] code);
        jbs_tester_inst.scan(1'b1, 16, 160'(code), so);
        chk("ir capture", so & 160'hFFFF, 160'(IR_CAPTURE));
    endtask

    task automatic dr(input int n, input logic [159:0] din);
        jbs_tester_inst.scan(1'b0, n, din, so);
    endtask

    // Boundary image that a capture must produce from the present pin and core levels.
    function automatic logic [159:0] cap_img();
        logic [159:0] v;
        v = '0;
        v[2] = core_drv.rst_oe;
        v[3] = pin_in.rst_pin;
        v[4] = pin_in.osc;
        v[5] = core_drv.wpu_en;
        for (int k = 0; k < 64; k++) begin
            v[6 + 2 * k] = core_drv.port_oe[k];
            v[7 + 2 * k] = pin_in.port[k];
        end
        return v;
    endfunction

    task automatic chk_pins(input logic [159:0] u);
        logic [63:0] oe;
        logic [63:0] dat;
        for (int k = 0; k < 64; k++) begin
            oe[k] = u[6 + 2 * k];
            dat[k] = u[7 + 2 * k];
        end
        chk("rst oe", 160'(pin_out.rst_oe), 160'(u[2]));
        chk("rst out", 160'(pin_out.rst_out), 160'(u[3]));
        chk("pullup", 160'(pin_out.wpu_en), 160'(u[5]));
        chk("port oe", 160'(pin_out.port_oe), 160'(oe));
        chk("port out", 160'(pin_out.port_out), 160'(dat));
        chk("core in", 160'({core_in.rst_pin, core_in.port}), 160'({65{1'b1}}));
    endtask

    task automatic chk_func();
        chk("func oe", 160'(pin_out.port_oe), 160'(core_drv.port_oe));
        chk("func out", 160'(pin_out.port_out), 160'(core_drv.port_out));
        chk("func pullup", 160'(pin_out.wpu_en), 160'(core_drv.wpu_en));
        chk("func rst oe", 160'(pin_out.rst_oe), 160'(core_drv.rst_oe));
        chk("func core rst", 160'(core_in.rst_pin), 160'(pin_in.rst_pin));
        chk("func core in", 160'(core_in.port), 160'(pin_in.port));
    endtask

    task automatic t_reset();
        chk("tdo enable", 160'(jtag_out.tdo_oe), 160'h0);
        chk_pins('0);
    endtask

    task automatic t_id();
        ir(OP_IDCODE);
        dr(32, '0);
        chk("id", so, 160'(ID_VALUE));
    endtask

    task automatic t_bypass();
        logic [15:0] codes [3] = '{OP_BYPASS, 16'h1234, 16'h0001};
        foreach (codes[i]) begin
            ir(codes[i]);
            dr(3, 160'h5);
            chk("bypass", so, 160'h2);
            chk_func();
        end
    endtask

    task automatic t_flash();
        logic [15:0] codes [3] = '{OP_FL_CTRL, OP_FL_ADDR, OP_FL_DATA};
        int w [3] = '{FC_W, FA_W, FD_W};
        logic [159:0] rv [3] = '{160'(FC_RESET), 160'(FA_RESET), 160'(FD_RESET)};
        logic [159:0] m;
        logic [159:0] pat;
        foreach (codes[i]) begin
            m = (160'd1 << w[i]) - 160'd1;
            pat = 160'h9C3A5 ^ 160'(i);
            ir(codes[i]);
            dr(w[i], pat);
            chk("flash reset", so, rv[i]);
            dr(w[i], ~pat);
            chk("flash hold", so, pat & m);
        end
    endtask

    // Waits for the pin side to settle and leaves the bench just after a clock edge.
    task automatic settle();
        repeat (10) @(posedge mclk);
        #1;
    endtask

    // Reset in mid-run must bring back the external test code and the flash control reset value.
    task automatic t_rerun();
        @(posedge mclk);
        #1;
        rst = 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        rst = 1'b0;
        jbs_tester_inst.tlr();
        chk_pins('0);
        ir(OP_FL_CTRL);
        dr(FC_W, 160'h5A);
        chk("flash after reset", so, 160'(FC_RESET));
    endtask

    task automatic t_boundary();
        p1 = 160'h3_1234_5678_9ABC_DEF0_0FED_CBA9_8765_4321;
        ir(OP_SAMPLE);
        settle();
        chk_func();
        dr(134, p1);
        chk("sample capture", so, cap_img());
        settle();
        pin_in.rst_pin = 1'b1;
        pin_in.osc = 1'b0;
        settle();
        chk_func();
        ir(OP_EXTEST);
        settle();
        chk_pins(p1);
        dr(135, {~p1[158:0], 1'b1});
        chk("extest capture", so, cap_img() | (160'd1 << 134));
        settle();
        chk_pins(160'(~p1[133:0]));
    endtask

    initial begin
        pin_in = {1'b0, 1'b1, 64'hA5C3_0F1E_7788_9ABC};
        core_drv = {1'b1, 1'b0, 64'h0123_4567_89AB_CDEF, 64'hFEDC_BA98_7654_3210};
        repeat (2) @(posedge mclk);
        #1;
        rst = 1'b0;
        jbs_tester_inst.tlr();
        t_reset();
        t_id();
        t_bypass();
        t_flash();
        t_rerun();
        t_boundary();
        conclude();
    end
endmodule
